// ===== rtl/aux_ctrl_pkg.sv
// Purpose: shared constants and carriers for the auxiliary control block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: register index kept as printed, byte address is four times it
package aux_ctrl_pkg;

    // ******************************************************************
    // register map
    // ******************************************************************
    localparam logic [7:0] auxiliary_control_index = 8'h8e;
    localparam logic [11:0] auxiliary_control_addr = 12'h238;
    localparam logic [11:0] ram_access_addr = 12'h240;
    localparam logic [11:0] bus_status_addr = 12'h244;

    // ******************************************************************
    // field positions and reset values
    // ******************************************************************
    localparam int strobe_disable_bit = 0;
    localparam int external_data_select_bit = 1;
    localparam int expanded_ram_size_lo_bit = 2;
    localparam int expanded_ram_size_hi_bit = 3;
    localparam int pulse_stretch_bit = 5;
    localparam int expanded_ram_cfg_bit = 3;
    localparam logic [7:0] writable_mask = 8'h2f;
    localparam logic [7:0] auxiliary_control_reset = 8'h00;
    localparam logic [7:0] security_byte_default = 8'hbb;

    // ******************************************************************
    // timing constants
    // ******************************************************************
    localparam logic [2:0] strobe_period_std = 3'd6;
    localparam logic [2:0] strobe_period_x2 = 3'd3;
    localparam logic [1:0] stretch_periods = 2'd3;
    localparam logic [1:0] plain_periods = 2'd1;
    localparam logic [10:0] ram_block_bytes = 11'h100;

    // external move request carrier
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } move_req_t;

    // external bus pins carrier
    typedef struct packed {
        logic ale_out;
        logic ale_oe_n;
        logic rd_n;
        logic wr_n;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ext_pins_t;

    typedef enum logic [2:0] {
        bus_idle = 3'b001,
        bus_strobe = 3'b010,
        bus_done = 3'b100
    } bus_state_t;

endpackage

// ===== rtl/ale_pacer.sv
// Purpose: free-running address latch strobe pacer
// Assumes: one tick per oscillator cycle (pclk with enable)
// Notes: period selectable between standard and double speed
module ale_pacer
    import aux_ctrl_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // control
    input wire logic double_speed_mode,
    // strobe out, one cycle per period
    output logic pulse
);
    logic [2:0] count;
    logic [2:0] period;

    // period picks one sixth or one third of the clock
    assign period = double_speed_mode ? strobe_period_x2 : strobe_period_std;

    // divider counter; pulse on the last count of each period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 3'd0;
            pulse <= 1'b0;
        end else if (clk_en) begin
            if (count >= period - 3'd1) begin
                count <= 3'd0;
                pulse <= 1'b1;
            end else begin
                count <= count + 3'd1;
                pulse <= 1'b0;
            end
        end
    end
endmodule // ale_pacer

// ===== rtl/ale_expanded_ram_aux_control.sv
// Overview of operation
// RULE1 - strobe disable keeps strobe only for bus moves; code also keeps it while code_fetch_ext is high
// RULE2 - suppressed strobe pin released to weak pullup
// RULE3 - default strobe at sixth, third in double
// RULE4 - stretch bit holds move strobes three periods
// RULE5 - size field selects 256 to 1024 bytes
// RULE6 - select bit steers moves internal or external
// RULE7 - select bit loaded from security byte at powerup
// RULE8 - software never sets reserved bits 7,6,4
// RULE9 - security byte bit 3 programmed inhibits ram
// RULE10 - beyond size moves go to external bus
//
// Purpose: auxiliary control register, strobe gating, data move routing
// Assumes: APB register access; moves arrive as one request struct
// Notes: expanded ram held locally as a byte array
//
// Design decision made here: the APB interface to the registers.
module ale_expanded_ram_aux_control
    import aux_ctrl_pkg::*;
#(
    parameter int ram_depth = 1024
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // straps and core status
    input wire logic [7:0] nonvolatile_security_byte,
    input wire logic double_speed_mode,
    input wire logic code_fetch_ext,
    // data move request from the core
    input wire move_req_t move_req,
    output logic move_done,
    output logic [7:0] move_rdata,
    // external memory bus
    output ext_pins_t pins,
    input wire logic [7:0] ext_rdata
);

    // ******************************************************************
    // register state
    // ******************************************************************
    logic [7:0] auxiliary_control;
    logic strap_pending;
    logic strobe_disable;
    logic external_data_select;
    logic pulse_stretch;
    logic [1:0] expanded_ram_size;
    logic [10:0] ram_limit;
    logic apb_write;
    logic apb_read;
    logic [7:0] ram [ram_depth];
    logic [7:0] ram_rdata_q;
    bus_state_t state;
    logic [1:0] strobe_cnt;
    logic move_internal;
    logic ext_active;
    logic pace_pulse;
    logic [15:0] ram_window;
    logic move_take;

    assign strobe_disable = auxiliary_control[strobe_disable_bit];
    assign external_data_select = auxiliary_control[external_data_select_bit];
    assign pulse_stretch = auxiliary_control[pulse_stretch_bit];
    assign expanded_ram_size = {auxiliary_control[expanded_ram_size_hi_bit],
                        auxiliary_control[expanded_ram_size_lo_bit]};
    assign apb_write = psel && penable && pwrite && clk_en;
    assign apb_read = psel && !penable && !pwrite && clk_en;

    // size field plus one, times one block of 256 bytes
    assign ram_limit = ram_block_bytes * (11'(expanded_ram_size) + 11'd1); // RULE5

    // moves inside the window go to ram unless steered out
    assign move_internal = !external_data_select &&
                           (move_req.addr < {5'd0, ram_limit}); // RULE6 RULE10
    assign ram_window = move_req.addr & 16'(ram_depth - 1);

    // a request still held during the done pulse is not taken twice
    assign move_take = clk_en && state == bus_idle && move_req.valid &&
                       !move_done;

    // ******************************************************************
    // register file
    // ******************************************************************
    // strap taken on the first enabled edge after reset release,
    // since an async reset may only load constants
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auxiliary_control <= auxiliary_control_reset;
            strap_pending <= 1'b1;
        end else if (clk_en) begin
            if (strap_pending) begin
                strap_pending <= 1'b0;
                auxiliary_control[external_data_select_bit] <=
                    !nonvolatile_security_byte[expanded_ram_cfg_bit]; // RULE7 RULE9
            end else if (apb_write && paddr == auxiliary_control_addr) begin
                // reserved bits stay clear whatever software writes
                auxiliary_control <= pwdata[7:0] & writable_mask; // RULE8
            end
        end
    end

    // apb answer: zero wait states, unmapped reads zero, no error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (apb_read) begin
                unique case (paddr)
                    auxiliary_control_addr: prdata <= {24'd0, auxiliary_control};
                    bus_status_addr: prdata <= {29'd0, state};
                    ram_access_addr: prdata <= {21'd0, ram_limit};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ******************************************************************
    // expanded ram
    // ******************************************************************
    // byte array, written or read in the first cycle of an internal move
    always_ff @(posedge pclk) begin
        if (move_take && move_internal) begin
            if (move_req.write) begin
                ram[ram_window[$clog2(ram_depth)-1:0]] <= move_req.wdata;
            end
            ram_rdata_q <= ram[ram_window[$clog2(ram_depth)-1:0]];
        end
    end

    // ******************************************************************
    // move sequencer
    // ******************************************************************
    // internal moves finish in one cycle; external ones drive the
    // strobes for one period, or three when stretching is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= bus_idle;
            strobe_cnt <= 2'd0;
            move_done <= 1'b0;
            move_rdata <= 8'h00;
            ext_active <= 1'b0;
        end else if (clk_en) begin
            move_done <= 1'b0;
            unique case (state)
                bus_idle: begin
                    if (move_take && move_internal) begin
                        state <= bus_done;
                    end else if (move_take) begin
                        state <= bus_strobe;
                        ext_active <= 1'b1;
                        strobe_cnt <= pulse_stretch ? stretch_periods
                                                    : plain_periods; // RULE4
                    end
                end
                bus_strobe: begin
                    if (strobe_cnt == 2'd1) begin
                        state <= bus_done;
                    end
                    strobe_cnt <= strobe_cnt - 2'd1;
                end
                bus_done: begin
                    // registered read strobe is still low on this edge,
                    // so external data is valid here, and with stretching off not earlier
                    move_rdata <= ext_active ? ext_rdata : ram_rdata_q;
                    move_done <= 1'b1;
                    ext_active <= 1'b0;
                    state <= bus_idle;
                end
            endcase
        end
    end

    // ******************************************************************
    // strobe pacing and pins
    // ******************************************************************
    ale_pacer u_pacer (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .double_speed_mode(double_speed_mode),
        .pulse(pace_pulse)
    );

    // pins registered so every output comes from a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins <= '{ale_out: 1'b0, ale_oe_n: 1'b0, rd_n: 1'b1,
                      wr_n: 1'b1, addr: 16'h0000, wdata: 8'h00};
        end else if (clk_en) begin
            if (!strobe_disable) begin
                pins.ale_out <= pace_pulse; // RULE3
                pins.ale_oe_n <= 1'b0;
            end else if (ext_active || code_fetch_ext) begin
                pins.ale_out <= pace_pulse; // RULE1
                pins.ale_oe_n <= 1'b0;
            end else begin
                // released; board pull-up holds the line high
                pins.ale_out <= 1'b1;
                pins.ale_oe_n <= 1'b1; // RULE2
            end
            pins.rd_n <= !(state == bus_strobe && !move_req.write);
            pins.wr_n <= !(state == bus_strobe && move_req.write);
            pins.addr <= move_req.addr;
            pins.wdata <= move_req.wdata;
        end
    end

endmodule // ale_expanded_ram_aux_control

// ===== tb/ale_expanded_ram_aux_control_props.sv
// Purpose: port timing checks on strobe, move and register reads
// Assumes: clk_en held high by the bench
// Notes: period checks pause while the strobe pin is released
module ale_expanded_ram_aux_control_props
    import aux_ctrl_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb and core status
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic double_speed_mode,
    input wire logic code_fetch_ext,
    // moves and bus pins
    input wire move_req_t move_req,
    input wire logic move_done,
    input wire ext_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // mode changes abort a check rather than fake a short period
    a_period_std: assert property (
        disable iff (!presetn || pins.ale_oe_n || double_speed_mode)
        $rose(pins.ale_out) |=> !pins.ale_out [*5] ##1 pins.ale_out)
        else $error("strobe period wrong in standard mode");
    a_period_fast: assert property (
        disable iff (!presetn || pins.ale_oe_n || !double_speed_mode)
        $rose(pins.ale_out) |=> !pins.ale_out [*2] ##1 pins.ale_out)
        else $error("strobe period wrong in double speed");
    a_released_high: assert property (
        pins.ale_oe_n |-> pins.ale_out)
        else $error("released strobe pin not high");
    a_fetch_keeps: assert property (
        code_fetch_ext && $past(code_fetch_ext) |-> !pins.ale_oe_n)
        else $error("strobe released during external fetch");
    a_move_keeps: assert property (
        !pins.rd_n || !pins.wr_n |-> !pins.ale_oe_n)
        else $error("strobe released during data move");
    a_read_width: assert property (
        $fell(pins.rd_n) |=> pins.rd_n or (!pins.rd_n [*2] ##1 pins.rd_n))
        else $error("read strobe width not 1 or 3");
    a_write_width: assert property (
        $fell(pins.wr_n) |=> pins.wr_n or (!pins.wr_n [*2] ##1 pins.wr_n))
        else $error("write strobe width not 1 or 3");
    a_move_answer: assert property (
        $rose(move_req.valid) |-> ##[2:5] move_done)
        else $error("move not answered in time");
    a_done_pulse: assert property (
        move_done |=> !move_done)
        else $error("move done longer than one cycle");
    a_reserved_zero: assert property (
        psel && penable && pready && !pwrite |-> prdata[7:6] == 2'b00
            && !prdata[4])
        else $error("reserved bits read nonzero");
endmodule // ale_expanded_ram_aux_control_props

// ===== tb/ext_mem_model.sv
// Purpose: external byte memory on the multiplexed bus
// Assumes: strobes low active, address and data held while low
// Notes: no pull on the data lines, so an idle bus reads inverted
module ext_mem_model
    import aux_ctrl_pkg::*;
(
    // clock and bus pins
    input wire logic pclk,
    input wire ext_pins_t pins,
    output logic [7:0] ext_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [int];
    logic [7:0] last = 8'h00;
    // store on every write-strobe cycle
    always @(posedge pclk) begin
        if (pins.wr_n === 1'b0) mem[pins.addr] = pins.wdata;
        if (pins.rd_n === 1'b0) last <= ext_rdata;
    end
    // drive only while read strobe low, else a value that misleads
    always @* begin
        if (pins.rd_n !== 1'b0) ext_rdata = ~last;
        else if (mem.exists(pins.addr)) ext_rdata = mem[pins.addr];
        else ext_rdata = ~pins.addr[7:0];
    end
endmodule // ext_mem_model

// ===== tb/test_ale_expanded_ram_aux_control.sv
// Purpose: self-checking bench for the auxiliary control block
// Assumes: zero-wait apb; move strobe counted as cycles seen low
// Notes: software never sets reserved bits, so writes are masked
module test_ale_expanded_ram_aux_control;
    import aux_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
    logic pwrite = 0, double_speed_mode = 0, code_fetch_ext = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, move_done;
    logic [7:0] nonvolatile_security_byte = 8'h00;
    logic [7:0] move_rdata, ext_rdata, areg = 8'h00;
    move_req_t move_req = '0;
    ext_pins_t pins;
    int err_total = 0, n_checks = 0;
    logic [7:0] mi [int], mx [int];
    always #5 pclk = ~pclk;
    ale_expanded_ram_aux_control dut_u (.pclk, .presetn, .clk_en, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .nonvolatile_security_byte, .double_speed_mode, .code_fetch_ext,
        .move_req, .move_done, .move_rdata, .pins, .ext_rdata);
    ext_mem_model mem_u (.pclk, .pins, .ext_rdata);
    task automatic report_and_stop;
        if (err_total == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; a stuck slave ends the run
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [7:0] d, output logic [31:0] r);
        int i;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) err_total++;
        if (i == 50) report_and_stop;
        r = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic wreg(input logic [7:0] v);
        logic [31:0] r;
        areg = v & writable_mask;
        apb(1, auxiliary_control_addr, areg, r);
    endtask
    task automatic rreg(input logic [7:0] e);
        logic [31:0] r;
        apb(0, auxiliary_control_addr, 8'h00, r);
        chk(r, {24'h0, e});
    endtask
    // one move; counts cycles with a strobe low until the done pulse
    task automatic mv(input logic w, input logic [15:0] a,
        input logic [7:0] d, output logic [7:0] r, output int n);
        int i;
        n = 0;
        r = 8'h00;
        move_req <= '{1'b1, w, a, d};
        for (i = 0; i < 40; i++) begin
            @(posedge pclk);
            n += (pins.rd_n === 1'b0 || pins.wr_n === 1'b0);
            if (move_done === 1'b1) break;
        end
        if (i == 40) err_total++;
        if (i == 40) report_and_stop;
        r = move_rdata;
        move_req.valid <= 0;
        // one idle edge before any next request
        @(posedge pclk);
    endtask
    // move against the model: route decides strobe count and data
    task automatic mc(input logic w, input logic [15:0] a);
        logic [7:0] d, r;
        int n;
        logic in;
        d = 8'($urandom);
        in = !areg[1] && a < 256 * (areg[3:2] + 1);
        mv(w, a, d, r, n);
        chk(n, in ? 0 : (areg[5] ? 3 : 1));
        if (w && in) mi[a] = d;
        if (w && !in) mx[a] = d;
        if (!w) chk(r, in ? mi[a] : mx[a]);
    endtask
    // count strobe rises over sixty cycles
    task automatic pace(input logic [7:0] e);
        int i, c;
        logic p;
        c = 0;
        // skip one edge so a pin change still in flight is not a rise
        @(posedge pclk);
        p = pins.ale_out;
        for (i = 0; i < 60; i++) begin
            @(posedge pclk);
            c += (pins.ale_out === 1'b1 && p === 1'b0);
            p = pins.ale_out;
        end
        chk(c, e);
    endtask
    task automatic rst(input logic [7:0] s);
        presetn <= 0;
        nonvolatile_security_byte <= s;
        repeat (8) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
    endtask
    initial begin
        logic [31:0] r;
        int k;
        void'($urandom(32'hc5b1));
        rst(security_byte_default);
        rreg(8'h00);
        apb(0, 12'h000, 8'h00, r);
        chk(r, 0);
        pace(10);
        wreg(8'h01);
        pace(0);
        chk(pins.ale_oe_n, 1);
        code_fetch_ext <= 1;
        repeat (3) @(posedge pclk);
        chk(pins.ale_oe_n, 0);
        code_fetch_ext <= 0;
        mc(1, 16'h0123);
        mc(0, 16'h0123);
        for (k = 0; k < 4; k++) begin
            wreg(8'(k << 2));
            mc(1, 16'(256 * (k + 1) - 1));
            mc(0, 16'(256 * (k + 1) - 1));
            mc(1, 16'(256 * (k + 1)));
            mc(0, 16'(256 * (k + 1)));
        end
        wreg(8'h22);
        mc(1, 16'h0010);
        mc(0, 16'h0010);
        repeat (4) begin
            wreg(8'($urandom));
            rreg(areg);
            k = $urandom & 16'h07ff;
            mc(1, 16'(k));
            mc(0, 16'(k));
        end
        wreg(8'h00);
        double_speed_mode <= 1;
        pace(20);
        rst(8'hb3);
        areg = 8'h02;
        rreg(8'h02);
        mc(1, 16'h0005);
        mc(0, 16'h0005);
        report_and_stop;
    end
endmodule // test_ale_expanded_ram_aux_control
bind ale_expanded_ram_aux_control ale_expanded_ram_aux_control_props chk_u (.pclk,
    .presetn, .psel, .penable, .pwrite, .prdata, .pready,
    .double_speed_mode, .code_fetch_ext, .move_req, .move_done, .pins);
